// file: csd_hostmem.sv
// Host memory model answering descriptor and buffer fetches
`default_nettype none
module csd_hostmem (
  input  wire logic        clk,  // Clock
  input  wire logic        req,  // Fetch wanted
  input  wire logic [31:0] addr, // Fetch address
  input  wire logic [3:0]  dly,  // Answer delay
  output logic             ack,  // Word back
  output logic [31:0]      data  // Word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [256];
  logic [3:0]  wait_ff;
  initial begin
    ack = 1'b0;
    data = 32'h0;
    wait_ff = 4'h0;
  end
  always @(posedge clk) begin
    ack <= 1'b0;
    data <= ~data; // Bus flips every bit of the last word each cycle between answers
    if (req && !ack && wait_ff >= dly) begin
      ack <= 1'b1;
      data <= mem[addr[9:2]]; // Word-aligned only
      wait_ff <= 4'h0;
    end else if (req && !ack) begin
      wait_ff <= wait_ff + 4'h1;
    end else begin
      wait_ff <= 4'h0;
    end
  end
endmodule : csd_hostmem
`default_nettype wire

// file: csd_monitor.sv
// Port checker for the status and transmit DMA launcher
`default_nettype none
module csd_monitor (
  input wire logic        SYS_CLK,      // Clock
  input wire logic        SRST,         // Reset
  input wire logic        PSEL,         // Select
  input wire logic        PENABLE,      // Enable
  input wire logic        PWRITE,       // Direction
  input wire logic [11:0] PADDR,        // Address
  input wire logic [31:0] PWDATA,       // Write data
  input wire logic        PREADY,       // Ready
  input wire logic [31:0] PRDATA,       // Read data
  input wire logic        PSLVERR,      // Error
  input wire logic        MRD_REQ,      // Fetch wanted
  input wire logic [31:0] MRD_ADDR,     // Fetch address
  input wire logic        MRD_ACK,      // Word back
  input wire logic [31:0] MRD_DATA,     // Word
  input wire logic        BUS_TABORT,   // Target abort
  input wire logic        BUS_MABORT,   // Master abort
  input wire logic        TXDMA_PUSH,   // Push
  input wire logic [31:0] TXDMA_WDATA,  // Pushed word
  input wire logic [12:0] TX_DMA_COUNT, // DMA FIFO words
  input wire logic [13:0] TX_II_COUNT,  // Second FIFO words
  input wire logic        TX_MOVE,      // Mover step
  input wire logic        IRQ_PENDING   // Request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  logic ptr_wr;
  assign ptr_wr = PSEL && PENABLE && PWRITE && PADDR == 12'h008;
  ready_no_err_a: assert property (PREADY && !PSLVERR)
    else $error("apb wait or error");
  reset_quiet_a: assert property ($fell(SRST) |-> !MRD_REQ && !IRQ_PENDING && PRDATA == 32'h0)
    else $error("outputs busy after reset");
  fetch_start_a: assert property (ptr_wr && PWDATA != 32'h0 && !MRD_REQ &&
    TX_DMA_COUNT != 13'h1000 |=> MRD_REQ && MRD_ADDR == ($past(PWDATA) & 32'hffff_fffc))
    else $error("fetch not started at pointer");
  fetch_hold_a: assert property (MRD_REQ && !MRD_ACK && !BUS_TABORT && !BUS_MABORT &&
    !ptr_wr && TX_DMA_COUNT < 13'h0ff0 |=> MRD_REQ && $stable(MRD_ADDR))
    else $error("fetch dropped before answer");
  zero_abort_a: assert property (ptr_wr && PWDATA == 32'h0 |=> !MRD_REQ)
    else $error("zero pointer did not stop fetch");
  bus_abort_a: assert property (MRD_REQ && (BUS_TABORT || BUS_MABORT) |=> !MRD_REQ)
    else $error("bus abort did not stop fetch");
  push_on_ack_a: assert property (TXDMA_PUSH |-> MRD_ACK && TXDMA_WDATA == MRD_DATA)
    else $error("push without returned word");
  move_guard_a: assert property (TX_MOVE |->
    TX_DMA_COUNT != 13'h0 && TX_II_COUNT != 14'h2000)
    else $error("move from empty or into full");
  move_fill_a: assert property (TX_II_COUNT < 14'h0010 && TX_DMA_COUNT != 13'h0
    |-> ##[0:2] TX_MOVE) else $error("mover idle while second fifo low");
  irq_read_a: assert property (PSEL && !PENABLE && !PWRITE && PADDR == 12'h004
    |=> PRDATA[31] == $past(IRQ_PENDING)) else $error("status irq bit differs");
endmodule : csd_monitor
`default_nettype wire

// file: csd_mover.sv
// Mover from the transmit DMA FIFO into the second transmit FIFO
`include "csd_params.svh"
`default_nettype none
module csd_mover (
  input  wire logic        clk,        // System clock
  input  wire logic        srst,       // Sync reset
  input  wire logic [12:0] dma_count,  // Words in DMA FIFO
  input  wire logic [13:0] ii_count,   // Words in second FIFO
  output logic             move,       // Pop DMA, push second
  output logic             ii_empty,   // Second FIFO empty
  output logic             ii_nempty,  // Under 0x10 words
  output logic             ii_nfull,   // Under 0x10 free
  output logic             ii_full     // Second FIFO full
);
  logic fill_ff;
  logic nxt_fill;

  always_comb begin
    ii_empty  = (ii_count == 14'h0000);
    ii_full   = (ii_count == `CSD_II_DEPTH);
    ii_nempty = (ii_count < `CSD_II_MARGIN);
    ii_nfull  = ((`CSD_II_DEPTH - ii_count) < `CSD_II_MARGIN);
  end

  // Hysteresis: fill from nearly empty until nearly full
  always_comb begin
    nxt_fill = fill_ff;
    if (ii_nempty) begin
      nxt_fill = 1'b1;
    end else if (ii_nfull) begin
      nxt_fill = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fill_ff <= 1'b0;
    end else begin
      fill_ff <= nxt_fill;
    end
  end

  assign move = fill_ff && !ii_full && (dma_count != 13'h0000);
endmodule : csd_mover
`default_nettype wire

// file: csd_params.svh
// Constants for the channel status and transmit DMA launcher
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH
`define CSD_OFS_CTRL      12'h000
`define CSD_OFS_STATUS    12'h004
`define CSD_OFS_TXPTR     12'h008
`define CSD_OFS_TXLVL     12'h014
`define CSD_OFS_RXLVL     12'h018
`define CSD_OFS_TXCTL     12'h01c
`define CSD_OFS_RXCTL     12'h020
`define CSD_II_DEPTH      14'h2000
`define CSD_II_MARGIN     14'h0010
`define CSD_DMA_DEPTH     13'h1000
`define CSD_EOC_BIT       0
`define CSD_DIR_BIT       1
`define CSD_CTL_MIE       3
`define CSD_CTL_FORCE     4
`define CSD_CTL_WDMA_IE   5
`define CSD_CTL_RDMA_IE   6
`define CSD_TXC_PKT_IE    2
`define CSD_TXC_AE_IE     3
`define CSD_TXC_UF_IE     4
`define CSD_RXC_PKT_IE    2
`define CSD_RXC_AF_IE     3
`define CSD_RXC_OF_IE     4
`define CSD_ST_RXPKT      9
`define CSD_ST_TXPKT      8
`define CSD_ST_TXLVL      10
`define CSD_ST_RXLVL      11
`define CSD_ST_WERR       12
`define CSD_ST_RERR       13
`define CSD_ST_WDONE      14
`define CSD_ST_RDONE      15
`define CSD_ST_UF         28
`define CSD_ST_OF         29
`endif

// file: csd_pkg.sv
// Types for the channel status and transmit DMA launcher
`default_nettype none
package csd_pkg;
  typedef enum logic [2:0] {
    CSD_IDLE  = 3'b000,
    CSD_RDADR = 3'b001,
    CSD_RDLEN = 3'b010,
    CSD_RDNXT = 3'b011,
    CSD_DATA  = 3'b100
  } csd_dma_state_t;
endpackage : csd_pkg
`default_nettype wire

// file: csd_top.sv
// Channel status register and transmit scatter-gather DMA launcher
`include "csd_params.svh"
`default_nettype none
module csd_top (
  input  wire logic        SYS_CLK,        // 20 MHz clock
  input  wire logic        SRST,           // Sync reset, high
  input  wire logic        PSEL,           // APB select
  input  wire logic        PENABLE,        // APB enable
  input  wire logic        PWRITE,         // APB direction
  input  wire logic [11:0] PADDR,          // APB byte address
  input  wire logic [31:0] PWDATA,         // APB write data
  output logic             PREADY,         // APB ready
  output logic [31:0]      PRDATA,         // APB read data
  output logic             PSLVERR,        // APB error
  output logic             MRD_REQ,        // Host memory read request
  output logic [31:0]      MRD_ADDR,       // Host memory address
  input  wire logic        MRD_ACK,        // Read word returned
  input  wire logic [31:0] MRD_DATA,       // Returned word
  input  wire logic        BUS_TABORT,     // Target abort
  input  wire logic        BUS_MABORT,     // Master abort
  output logic             TXDMA_PUSH,     // Data word into DMA FIFO
  output logic [31:0]      TXDMA_WDATA,    // Data word
  input  wire logic [12:0] TX_DMA_COUNT,   // DMA FIFO words
  input  wire logic [13:0] TX_II_COUNT,    // Second FIFO words
  output logic             TX_MOVE,        // Move one word
  input  wire logic [31:0] RX_CHAIN_COUNT, // Rx FIFO chain words
  input  wire logic        RX_DMA_EMPTY,   // Rx DMA FIFO empty
  input  wire logic        RX_DMA_FULL,    // Rx DMA FIFO full
  input  wire logic        TX_IDLE,        // Tx state machine idle
  input  wire logic        RX_IDLE,        // Rx state machine idle
  input  wire logic        TX_PKT_DONE,    // Tx packet finished
  input  wire logic        RX_PKT_DONE,    // Rx packet finished
  input  wire logic        TX_NEED_WORD,   // Tx wants next word
  input  wire logic        RX_PUT_WORD,    // Rx writes word
  input  wire logic        BI_BUSY,        // Burst-in engine busy
  input  wire logic        BO_BUSY,        // Burst-out engine busy
  input  wire logic        RD_DMA_DONE,    // Rx list complete
  input  wire logic        RD_DMA_ERR,     // Rx DMA error
  input  wire logic [5:0]  EXT_FLAGS,      // b,a full; b,a half; b,a empty
  output logic             IRQ_PENDING     // Channel interrupt request
);
  logic [31:0] ctrl_ff;
  logic [15:0] txlvl_ff;
  logic [31:0] rxlvl_ff;
  logic [4:0]  txc_ff;
  logic [4:0]  rxc_ff;
  logic [31:0] rdata_ff;
  logic [31:0] status;
  logic        lat_rxpkt_ff;
  logic        lat_txpkt_ff;
  logic        lat_txlvl_ff;
  logic        lat_rxlvl_ff;
  logic        lat_werr_ff;
  logic        lat_rerr_ff;
  logic        lat_wdone_ff;
  logic        lat_rdone_ff;
  logic        lat_uf_ff;
  logic        lat_of_ff;
  logic        rx_nfull_ff;
  logic        tx_nempty_ff;
  logic        nxt_rx_nfull;
  logic        rx_nfull_d_ff;
  logic        tx_nempty_d_ff;
  logic [5:0]  ext_s1_ff;
  logic [5:0]  ext_s2_ff;
  logic        wr;
  logic        rd;
  logic        wr_status;
  logic        wr_ptr;
  logic        ii_empty;
  logic        ii_nempty;
  logic        ii_nfull;
  logic        ii_full;
  logic [31:0] tx_total;
  logic        local_irq;
  logic        irq_status;
  logic        dma_err_ev;
  logic        dma_done_ev;
  csd_pkg::csd_dma_state_t st_ff;
  logic [31:0] buf_adr_ff;
  logic [31:0] len_ff;
  logic [31:0] nxt_ptr_ff;
  logic [31:0] mrd_addr_ff;
  logic        last_ff;
  logic        dma_full;
  logic        bi_idle;

  // Latched event: set wins over write-one clear
  function automatic logic ev_next(input logic cur, input logic set,
                                   input logic clr);
    ev_next = set | (cur & ~clr);
  endfunction : ev_next

  // Descriptor pointers sit on long-word boundaries; buffer addresses are used as fetched
  function automatic logic [31:0] word_align(input logic [31:0] adr);
    word_align = {adr[31:2], 2'b00};
  endfunction : word_align

  assign wr        = PSEL && PENABLE && PWRITE;
  assign rd        = PSEL && !PENABLE && !PWRITE;
  assign wr_status = wr && (PADDR == `CSD_OFS_STATUS);
  assign wr_ptr    = wr && (PADDR == `CSD_OFS_TXPTR);
  assign PREADY    = 1'b1;
  assign PSLVERR   = 1'b0;
  assign PRDATA    = rdata_ff;

  csd_mover u_mover (
    .clk       (SYS_CLK),
    .srst      (SRST),
    .dma_count (TX_DMA_COUNT),
    .ii_count  (TX_II_COUNT),
    .move      (TX_MOVE),
    .ii_empty  (ii_empty),
    .ii_nempty (ii_nempty),
    .ii_nfull  (ii_nfull),
    .ii_full   (ii_full)
  );

  // External queue flags are asynchronous to this clock
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ext_s1_ff <= 6'h00;
      ext_s2_ff <= 6'h00;
    end else begin
      ext_s1_ff <= EXT_FLAGS;
      ext_s2_ff <= ext_s1_ff;
    end
  end

  // Control registers
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ctrl_ff  <= 32'h0000_0000;
      txlvl_ff <= 16'h0000;
      rxlvl_ff <= 32'h0000_0000;
      txc_ff   <= 5'h00;
      rxc_ff   <= 5'h00;
    end else if (wr) begin
      case (PADDR)
        `CSD_OFS_CTRL:  ctrl_ff  <= PWDATA;
        `CSD_OFS_TXLVL: txlvl_ff <= PWDATA[15:0];
        `CSD_OFS_RXLVL: rxlvl_ff <= PWDATA;
        `CSD_OFS_TXCTL: txc_ff   <= PWDATA[4:0];
        `CSD_OFS_RXCTL: rxc_ff   <= PWDATA[4:0];
        default: begin
        end
      endcase
    end
  end

  assign tx_total = {19'h00000, TX_DMA_COUNT} + {18'h00000, TX_II_COUNT};
  assign dma_full = (TX_DMA_COUNT == `CSD_DMA_DEPTH);
  // Own descriptor walker is the burst-in engine, so it counts as busy too
  assign bi_idle  = !BI_BUSY && (st_ff == csd_pkg::CSD_IDLE);

  // Rx nearly-full holds when count equals level
  always_comb begin
    nxt_rx_nfull = rx_nfull_ff;
    if (RX_CHAIN_COUNT > rxlvl_ff) begin
      nxt_rx_nfull = 1'b1;
    end else if (RX_CHAIN_COUNT < rxlvl_ff) begin
      nxt_rx_nfull = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rx_nfull_ff    <= 1'b0;
      tx_nempty_ff   <= 1'b1;
      rx_nfull_d_ff  <= 1'b0;
      tx_nempty_d_ff <= 1'b1;
    end else begin
      rx_nfull_ff    <= nxt_rx_nfull;
      tx_nempty_ff   <= (tx_total <= {16'h0000, txlvl_ff});
      rx_nfull_d_ff  <= rx_nfull_ff;
      tx_nempty_d_ff <= tx_nempty_ff;
    end
  end

  assign dma_err_ev  = (st_ff != csd_pkg::CSD_IDLE) && (BUS_TABORT || BUS_MABORT ||
                       (MRD_ACK && st_ff == csd_pkg::CSD_RDNXT &&
                        MRD_DATA[`CSD_DIR_BIT]));
  // A zero-length last descriptor ends the list at its pointer word
  assign dma_done_ev = MRD_ACK && !dma_err_ev &&
                       (((st_ff == csd_pkg::CSD_DATA) && last_ff &&
                         (len_ff == 32'h0000_0004)) ||
                        ((st_ff == csd_pkg::CSD_RDNXT) &&
                         (len_ff == 32'h0000_0000) && MRD_DATA[`CSD_EOC_BIT]));

  // Latched events
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      lat_rxpkt_ff <= 1'b0;
      lat_txpkt_ff <= 1'b0;
      lat_txlvl_ff <= 1'b0;
      lat_rxlvl_ff <= 1'b0;
      lat_werr_ff  <= 1'b0;
      lat_rerr_ff  <= 1'b0;
      lat_wdone_ff <= 1'b0;
      lat_rdone_ff <= 1'b0;
      lat_uf_ff    <= 1'b0;
      lat_of_ff    <= 1'b0;
    end else begin
      lat_rxpkt_ff <= ev_next(lat_rxpkt_ff, RX_PKT_DONE,
                              wr_status && PWDATA[`CSD_ST_RXPKT]);
      lat_txpkt_ff <= ev_next(lat_txpkt_ff, TX_PKT_DONE,
                              wr_status && PWDATA[`CSD_ST_TXPKT]);
      lat_txlvl_ff <= ev_next(lat_txlvl_ff, tx_nempty_ff && !tx_nempty_d_ff,
                              wr_status && PWDATA[`CSD_ST_TXLVL]);
      lat_rxlvl_ff <= ev_next(lat_rxlvl_ff, rx_nfull_ff && !rx_nfull_d_ff,
                              wr_status && PWDATA[`CSD_ST_RXLVL]);
      lat_werr_ff  <= ev_next(lat_werr_ff, dma_err_ev,
                              wr_status && PWDATA[`CSD_ST_WERR]);
      lat_rerr_ff  <= ev_next(lat_rerr_ff, RD_DMA_ERR,
                              wr_status && PWDATA[`CSD_ST_RERR]);
      lat_wdone_ff <= ev_next(lat_wdone_ff, dma_done_ev,
                              wr_status && PWDATA[`CSD_ST_WDONE]);
      lat_rdone_ff <= ev_next(lat_rdone_ff, RD_DMA_DONE,
                              wr_status && PWDATA[`CSD_ST_RDONE]);
      // Underflow judged on the second FIFO, which feeds the port
      lat_uf_ff    <= ev_next(lat_uf_ff, TX_NEED_WORD && ii_empty,
                              wr_status && PWDATA[`CSD_ST_UF]);
      lat_of_ff    <= ev_next(lat_of_ff, RX_PUT_WORD && RX_DMA_FULL,
                              wr_status && PWDATA[`CSD_ST_OF]);
    end
  end

  assign local_irq = ctrl_ff[`CSD_CTL_FORCE] |
                     (lat_txpkt_ff & txc_ff[`CSD_TXC_PKT_IE]) |
                     (lat_txlvl_ff & txc_ff[`CSD_TXC_AE_IE]) |
                     (lat_uf_ff    & txc_ff[`CSD_TXC_UF_IE]) |
                     (lat_rxpkt_ff & rxc_ff[`CSD_RXC_PKT_IE]) |
                     (lat_rxlvl_ff & rxc_ff[`CSD_RXC_AF_IE]) |
                     (lat_of_ff    & rxc_ff[`CSD_RXC_OF_IE]);
  // DMA sources are enabled separately from the master enable
  assign irq_status = (local_irq & ctrl_ff[`CSD_CTL_MIE]) |
                      (lat_wdone_ff & ctrl_ff[`CSD_CTL_WDMA_IE]) |
                      (lat_rdone_ff & ctrl_ff[`CSD_CTL_RDMA_IE]);
  assign IRQ_PENDING = irq_status;

  // Rx flags from FIFO only, pipeline excluded
  assign status = {irq_status, local_irq, lat_of_ff, lat_uf_ff,
                   ii_full, ii_nfull, ii_nempty, ii_empty,
                   bi_idle, ~BO_BUSY,
                   ext_s2_ff,
                   lat_rdone_ff, lat_wdone_ff, lat_rerr_ff, lat_werr_ff,
                   lat_rxlvl_ff, lat_txlvl_ff, lat_rxpkt_ff, lat_txpkt_ff,
                   RX_IDLE, RX_DMA_FULL, rx_nfull_ff, RX_DMA_EMPTY,
                   TX_IDLE, dma_full, tx_nempty_ff,
                   (TX_DMA_COUNT == 13'h0000)};

  // Read data registered in the setup cycle; pointer port reads zero
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd) begin
      case (PADDR)
        `CSD_OFS_CTRL:   rdata_ff <= ctrl_ff;
        `CSD_OFS_STATUS: rdata_ff <= status;
        `CSD_OFS_TXLVL:  rdata_ff <= {16'h0000, txlvl_ff};
        `CSD_OFS_RXLVL:  rdata_ff <= rxlvl_ff;
        `CSD_OFS_TXCTL:  rdata_ff <= {27'h0000000, txc_ff};
        `CSD_OFS_RXCTL:  rdata_ff <= {27'h0000000, rxc_ff};
        default:         rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Descriptor walker; data words stream until length reaches zero
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      st_ff       <= csd_pkg::CSD_IDLE;
      buf_adr_ff  <= 32'h0000_0000;
      len_ff      <= 32'h0000_0000;
      nxt_ptr_ff  <= 32'h0000_0000;
      mrd_addr_ff <= 32'h0000_0000;
      last_ff     <= 1'b0;
    // Zero pointer wins, even over an answer arriving in the same cycle
    end else if (wr_ptr && PWDATA == 32'h0000_0000) begin
      st_ff <= csd_pkg::CSD_IDLE;
    end else if (dma_err_ev) begin
      st_ff <= csd_pkg::CSD_IDLE;
    end else begin
      case (st_ff)
        csd_pkg::CSD_IDLE: begin
          if (wr_ptr) begin
            mrd_addr_ff <= word_align(PWDATA);
            last_ff     <= 1'b0;
            st_ff       <= csd_pkg::CSD_RDADR;
          end
        end
        csd_pkg::CSD_RDADR: begin
          if (MRD_ACK) begin
            buf_adr_ff  <= MRD_DATA;
            mrd_addr_ff <= mrd_addr_ff + 32'h0000_0004;
            st_ff       <= csd_pkg::CSD_RDLEN;
          end
        end
        csd_pkg::CSD_RDLEN: begin
          if (MRD_ACK) begin
            len_ff      <= MRD_DATA;
            mrd_addr_ff <= mrd_addr_ff + 32'h0000_0004;
            st_ff       <= csd_pkg::CSD_RDNXT;
          end
        end
        csd_pkg::CSD_RDNXT: begin
          if (MRD_ACK) begin
            nxt_ptr_ff  <= word_align(MRD_DATA);
            last_ff     <= MRD_DATA[`CSD_EOC_BIT];
            mrd_addr_ff <= buf_adr_ff;
            // Zero length skips the data fetch
            st_ff       <= (len_ff == 32'h0000_0000) ?
                           (MRD_DATA[`CSD_EOC_BIT] ? csd_pkg::CSD_IDLE
                                                   : csd_pkg::CSD_RDADR)
                           : csd_pkg::CSD_DATA;
            if (len_ff == 32'h0000_0000) begin
              mrd_addr_ff <= word_align(MRD_DATA);
            end
          end
        end
        csd_pkg::CSD_DATA: begin
          if (MRD_ACK) begin
            len_ff      <= len_ff - 32'h0000_0004;
            mrd_addr_ff <= mrd_addr_ff + 32'h0000_0004;
            if (len_ff == 32'h0000_0004) begin
              mrd_addr_ff <= nxt_ptr_ff;
              st_ff <= last_ff ? csd_pkg::CSD_IDLE : csd_pkg::CSD_RDADR;
            end
          end
        end
        default: st_ff <= csd_pkg::CSD_IDLE;
      endcase
    end
  end

  // DMA FIFO back-pressure stalls the data fetch
  assign MRD_REQ     = (st_ff != csd_pkg::CSD_IDLE) &&
                       !(st_ff == csd_pkg::CSD_DATA && dma_full);
  assign MRD_ADDR    = mrd_addr_ff;
  assign TXDMA_PUSH  = (st_ff == csd_pkg::CSD_DATA) && MRD_ACK;
  assign TXDMA_WDATA = MRD_DATA;
endmodule : csd_top
`default_nettype wire

// file: tb_csd_top.sv
// Testbench for the status and transmit DMA launcher
`default_nettype none
module tb_csd_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] padr = 12'h0;
  logic [31:0] pwd = 32'h0;
  logic        prdy, perr, mreq, mack, push, move, irq;
  logic [31:0] prd, madr, mdat, wdat;
  logic [1:0]  abt = 2'b0;
  logic [12:0] dcnt = 13'h0;
  logic [13:0] icnt = 14'h0;
  logic [31:0] rcnt = 32'h0;
  logic        remp = 1'b1;
  logic        rful = 1'b0;
  logic        tidl = 1'b1;
  logic        ridl = 1'b1;
  logic [5:0]  pls = 6'h0;
  logic        bib = 1'b0;
  logic        bob = 1'b0;
  logic [5:0]  ext = 6'h03;
  logic [3:0]  dly = 4'h3;
  logic [31:0] pushed [$];
  int          mismatches = 0;
  int          samples_checked = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (push === 1'b1) pushed.push_back(wdat);
  csd_top i_csd_top (.SYS_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(padr), .PWDATA(pwd), .PREADY(prdy), .PRDATA(prd), .PSLVERR(perr), .MRD_REQ(mreq),
    .MRD_ADDR(madr), .MRD_ACK(mack), .MRD_DATA(mdat), .BUS_TABORT(abt[0]),
    .BUS_MABORT(abt[1]), .TXDMA_PUSH(push), .TXDMA_WDATA(wdat), .TX_DMA_COUNT(dcnt),
    .TX_II_COUNT(icnt), .TX_MOVE(move), .RX_CHAIN_COUNT(rcnt), .RX_DMA_EMPTY(remp),
    .RX_DMA_FULL(rful), .TX_IDLE(tidl), .RX_IDLE(ridl), .TX_PKT_DONE(pls[0]),
    .RX_PKT_DONE(pls[1]), .TX_NEED_WORD(pls[2]), .RX_PUT_WORD(pls[3]), .BI_BUSY(bib),
    .BO_BUSY(bob), .RD_DMA_DONE(pls[4]), .RD_DMA_ERR(pls[5]), .EXT_FLAGS(ext),
    .IRQ_PENDING(irq));
  csd_hostmem i_csd_hostmem (.clk(clk), .req(mreq), .addr(madr), .dly(dly), .ack(mack),
    .data(mdat));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwr, padr, pwd} <= {1'b1, w, a, v};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    r = prd;
    {psel, pen} <= 2'b00;
    if (n >= 50) begin
      mismatches++;
      give_verdict();
    end
  endtask : apb
  task automatic sbit(input int b, input logic e);
    logic [31:0] d;
    repeat (4) @(posedge clk);
    apb(1'b0, 12'h004, 32'h0, d);
    chk($sformatf("status bit %0d", b), {31'h0, e}, {31'h0, d[b]});
  endtask : sbit
  task automatic wait_stop;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (mreq !== 1'b0 && n < 400);
    chk("fetch stopped", 32'h0, {31'h0, mreq});
    if (n >= 400) give_verdict();
  endtask : wait_stop
  task automatic t_reset;
    logic [31:0] d;
    repeat (4) @(posedge clk);
    apb(1'b0, 12'h004, 32'h0, d);
    chk("status at rest", 32'h03c3_009b, d);
    {tidl, bob, bib, remp, ext} <= {4'b0110, 6'h3c};
    repeat (4) @(posedge clk);
    apb(1'b0, 12'h004, 32'h0, d);
    chk("status moved", 32'h033c_0083, d);
    {tidl, bob, bib, remp, ext} <= {4'b1001, 6'h03};
    apb(1'b0, 12'h030, 32'h0, d);
    chk("unmapped read", 32'h0, d);
    $display("test reset done");
  endtask : t_reset
  task automatic t_levels;
    logic [31:0] d;
    logic [13:0] ic [5] = '{14'h000f, 14'h0010, 14'h1ff0, 14'h1ff1, 14'h2000};
    logic [3:0]  ef [5] = '{4'b0010, 4'b0000, 4'b0000, 4'b0100, 4'b1100};
    apb(1'b1, 12'h014, 32'h5, d);
    apb(1'b1, 12'h018, 32'h5, d);
    {dcnt, icnt} <= {13'h3, 14'h3};
    sbit(1, 1'b0);
    icnt <= 14'h2;
    sbit(1, 1'b1);
    sbit(10, 1'b1);
    rcnt <= 32'h6;
    sbit(5, 1'b1);
    sbit(11, 1'b1);
    rcnt <= 32'h4;
    sbit(5, 1'b0);
    for (int i = 0; i < 5; i++) begin
      icnt <= ic[i];
      repeat (4) @(posedge clk);
      apb(1'b0, 12'h004, 32'h0, d);
      chk("second fifo flags", {28'h0, ef[i]}, {28'h0, d[27:24]});
    end
    apb(1'b1, 12'h004, 32'h0000_0c00, d);
    sbit(10, 1'b0);
    $display("test levels done");
  endtask : t_levels
  task automatic t_events;
    logic [31:0] d;
    int pos [6] = '{8, 9, 28, 29, 15, 13};
    {icnt, rful} <= {14'h0, 1'b1};
    for (int i = 0; i < 6; i++) begin
      pls[i] <= 1'b1;
      @(posedge clk);
      pls <= 6'h0;
      sbit(pos[i], 1'b1);
      apb(1'b1, 12'h004, 32'h1 << pos[i], d);
      sbit(pos[i], 1'b0);
    end
    pls[0] <= 1'b1;
    @(posedge clk);
    pls <= 6'h0;
    fork
      apb(1'b1, 12'h004, 32'h0000_0100, d);
      begin
        repeat (2) @(posedge clk);
        pls[0] <= 1'b1;
        @(posedge clk);
        pls[0] <= 1'b0;
      end
    join
    sbit(8, 1'b1);
    apb(1'b1, 12'h01c, 32'h4, d);
    sbit(30, 1'b1);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h000, 32'h8, d);
    sbit(31, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_0100, d);
    sbit(30, 1'b0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h000, 32'h18, d);
    sbit(31, 1'b1);
    apb(1'b1, 12'h000, 32'h0, d);
    {icnt, rful} <= {14'h20, 1'b0};
    $display("test events done");
  endtask : t_events
  task automatic put(input logic [9:0] a, input logic [31:0] v);
    i_csd_hostmem.mem[a[9:2]] = v;
  endtask : put
  task automatic t_dma;
    logic [31:0] d;
    int n;
    n = 0;
    put(10'h040, 32'h80);
    put(10'h044, 32'h8);
    put(10'h048, 32'h50);
    put(10'h050, 32'h90);
    put(10'h054, 32'h4);
    put(10'h058, 32'h1);
    put(10'h080, 32'ha1a1_0001);
    put(10'h084, 32'ha1a1_0002);
    put(10'h090, 32'ha1a1_0003);
    sbit(23, 1'b1);
    apb(1'b1, 12'h008, 32'h40, d);
    while (pushed.size() < 3 && n < 400) begin
      @(posedge clk);
      n++;
    end
    for (int i = 0; i < 3; i++) begin
      chk("pushed word", 32'ha1a1_0001 + i, (i < pushed.size()) ? pushed[i] : 32'h0);
    end
    if (n >= 400) give_verdict();
    wait_stop();
    sbit(14, 1'b1);
    apb(1'b1, 12'h000, 32'h28, d);
    @(posedge clk);
    chk("dma irq", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h004, 32'h0000_4000, d);
    @(posedge clk);
    chk("dma irq cleared", 32'h0, {31'h0, irq});
    put(10'h060, 32'h80);
    put(10'h064, 32'h4);
    put(10'h068, 32'h2);
    dly <= 4'h0;
    apb(1'b1, 12'h008, 32'h60, d);
    wait_stop();
    sbit(12, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_1000, d);
    sbit(12, 1'b0);
    dly <= 4'hf;
    apb(1'b1, 12'h008, 32'h40, d);
    sbit(23, 1'b0);
    apb(1'b1, 12'h008, 32'h0, d);
    @(posedge clk);
    chk("abort stops fetch", 32'h0, {31'h0, mreq});
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 12'h008, 32'h40, d);
      repeat (2) @(posedge clk);
      abt <= 2'b01 << i;
      @(posedge clk);
      abt <= 2'b00;
      wait_stop();
      sbit(12, 1'b1);
      apb(1'b1, 12'h004, 32'h0000_1000, d);
    end
    $display("test dma done");
  endtask : t_dma
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_levels();
    t_events();
    t_dma();
    give_verdict();
  end
endmodule : tb_csd_top
bind csd_top csd_monitor i_csd_monitor (.SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PRDATA(PRDATA), .PSLVERR(PSLVERR), .MRD_REQ(MRD_REQ), .MRD_ADDR(MRD_ADDR),
  .MRD_ACK(MRD_ACK), .MRD_DATA(MRD_DATA), .BUS_TABORT(BUS_TABORT), .BUS_MABORT(BUS_MABORT),
  .TXDMA_PUSH(TXDMA_PUSH), .TXDMA_WDATA(TXDMA_WDATA), .TX_DMA_COUNT(TX_DMA_COUNT),
  .TX_II_COUNT(TX_II_COUNT), .TX_MOVE(TX_MOVE), .IRQ_PENDING(IRQ_PENDING));
`default_nettype wire
